// File: include/ebu_pkg.sv
// Shared constants, field positions and types of the external bus unit.
package ebu_pkg;

    localparam int REG_AW = 4;
    localparam int WIN_NUM = 4;

    localparam logic [3:0] IDX_SYSCFG = 4'h0;
    localparam logic [3:0] IDX_STATUS = 4'h1;
    localparam logic [3:0] IDX_PORTDIR = 4'h2;
    localparam logic [3:0] IDX_PORTOUT = 4'h3;
    localparam logic [3:0] IDX_PORTIN = 4'h4;
    localparam logic [3:0] IDX_BUSCFG0 = 4'h5;
    localparam logic [3:0] IDX_WINSEL1 = 4'ha;

    localparam int SYS_ARB_EN = 0;
    localparam int SYS_SEG_LO = 1;
    localparam int SYS_SLAVE = 3;

    localparam logic [1:0] SEG_16M = 2'h0;
    localparam logic [1:0] SEG_1M = 2'h1;
    localparam logic [1:0] SEG_256K = 2'h2;
    localparam logic [7:0] SEGMASK_16M = 8'hff;
    localparam logic [7:0] SEGMASK_1M = 8'h0f;
    localparam logic [7:0] SEGMASK_256K = 8'h03;
    localparam logic [7:0] SEGMASK_64K = 8'h00;

    localparam int CFG_WAIT_LO = 0;
    localparam int CFG_TRI = 4;
    localparam int CFG_ALE_LONG = 5;
    localparam int CFG_RW_DLY = 6;
    localparam int CFG_MUX = 7;
    localparam int CFG_BUS16 = 8;
    localparam int CFG_WRL = 9;
    localparam int CFG_READY = 10;
    localparam int CFG_ACTIVE = 11;

    localparam logic [15:0] SYSCFG_RST = 16'h0000;
    localparam logic [15:0] BUSCFG_RST = 16'h0000;
    localparam logic [15:0] WINSEL_RST = 16'h0000;
    localparam logic [15:0] PORT_RST = 16'h0000;
    localparam logic [3:0] ALE_LONG_CNT = 4'h1;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [2:0] WIN_DEFAULT = 3'h0;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_DELAY,
        PH_DATA,
        PH_RECOVER,
        PH_HELD
    } ebu_phase_t;

    typedef struct packed {
        logic write;
        logic byteAcc;
        logic [23:0] addr;
        logic [15:0] wdata;
    } ebu_req_t;

    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oeN;
    } ebu_pin16_t;

    // Window hit: base is A23..A12, size code widens the window by powers of two.
    function automatic logic windowHit(input logic [23:0] addr, input logic [15:0] sel);
        logic [11:0] diff;
        diff = addr[23:12] ^ sel[15:4];
        return (diff >> sel[3:0]) == 12'h000;
    endfunction : windowHit

endpackage : ebu_pkg

// File: rtl/ebu_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
module ebu_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [1:0][W-1:0] s_q;
    logic [1:0][W-1:0] s_d;

    always_comb begin
        s_d = {s_q[0], d};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q[1];
endmodule : ebu_sync

// File: rtl/ebu_win_decode.sv
// Address window decoder with fixed precedence and default fallback.
`timescale 1ns/1ps
module ebu_win_decode (
    input wire logic [23:0] addr,
    input wire logic [3:0][15:0] winSel,
    input wire logic [4:0][15:0] busCfg,
    output logic [2:0] win,
    output logic [15:0] cfg
);
    always_comb begin
        win = ebu_pkg::WIN_DEFAULT;
        for (int i = 1; i <= ebu_pkg::WIN_NUM; i++) begin
            if (busCfg[i][ebu_pkg::CFG_ACTIVE] && ebu_pkg::windowHit(addr, winSel[i-1])) begin
                win = 3'(i);
            end
        end
        cfg = busCfg[win];
    end
endmodule : ebu_win_decode

// File: rtl/ebu_core.sv
// External bus unit: bus modes, timing, windows, chip selects and arbitration.
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module ebu_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ebu_pkg::REG_AW-1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWe,
    input wire logic regRe,
    output logic [15:0] regRdata,
    input wire logic reqValid,
    input wire ebu_pkg::ebu_req_t req,
    output logic reqReady,
    output logic rspValid,
    output logic [15:0] rspRdata,
    output ebu_pkg::ebu_pin16_t adPin,
    input wire logic [15:0] adIn,
    output ebu_pkg::ebu_pin16_t addrPin,
    input wire logic [15:0] addrIn,
    output logic [7:0] segOut,
    output logic [7:0] segOeN,
    output logic [4:0] csN,
    output logic ale,
    output logic rdN,
    output logic wrN,
    output logic strobeOeN,
    input wire logic ready,
    input wire logic holdN,
    output logic holdAckOutN,
    output logic holdAckOeN,
    input wire logic holdAckInN,
    output logic busReqN
);
    typedef struct packed {
        ebu_pkg::ebu_phase_t phase;
        logic [15:0] sysCfg;
        logic [4:0][15:0] busCfg;
        logic [3:0][15:0] winSel;
        logic [15:0] portDir;
        logic [15:0] portOut;
        logic [15:0] regRdata;
        ebu_pkg::ebu_req_t req;
        logic [2:0] win;
        logic [15:0] cfg;
        logic [3:0] cnt;
        logic second;
        logic addrPortBus;
        logic holdAck;
        logic rspValid;
        logic [15:0] rdata;
    } ebu_core_state_t;

    ebu_core_state_t s_q;
    ebu_core_state_t s_d;
    logic readySync;
    logic holdSyncN;
    logic ackInSyncN;
    logic [15:0] adSync;
    logic [15:0] addrSync;
    logic [2:0] decWin;
    logic [15:0] decCfg;
    logic arbEn;
    logic slave;
    logic ownBus;
    logic anyDemux;
    logic inCycle;
    logic mux;
    logic bus16;
    logic [15:0] laneData;
    logic [7:0] segMask;

    ebu_sync #(.W(1)) syncReady (.clk(clk), .rst(rst), .d(ready), .q(readySync));
    ebu_sync #(.W(1)) syncHold (.clk(clk), .rst(rst), .d(holdN), .q(holdSyncN));
    ebu_sync #(.W(1)) syncAck (.clk(clk), .rst(rst), .d(holdAckInN), .q(ackInSyncN));
    ebu_sync #(.W(16)) syncAd (.clk(clk), .rst(rst), .d(adIn), .q(adSync));
    ebu_sync #(.W(16)) syncAddr (.clk(clk), .rst(rst), .d(addrIn), .q(addrSync));

    ebu_win_decode decode (
        .addr(req.addr),
        .winSel(s_q.winSel),
        .busCfg(s_q.busCfg),
        .win(decWin),
        .cfg(decCfg)
    );

    assign arbEn = s_q.sysCfg[ebu_pkg::SYS_ARB_EN];
    assign slave = s_q.sysCfg[ebu_pkg::SYS_SLAVE];
    assign ownBus = !(arbEn && slave) || !ackInSyncN;
    assign reqReady = (s_q.phase == ebu_pkg::PH_IDLE) && ownBus && !(arbEn && !slave && !holdSyncN);
    assign mux = s_q.cfg[ebu_pkg::CFG_MUX];
    assign bus16 = s_q.cfg[ebu_pkg::CFG_BUS16];
    assign inCycle = (s_q.phase == ebu_pkg::PH_ADDR) || (s_q.phase == ebu_pkg::PH_DELAY)
        || (s_q.phase == ebu_pkg::PH_DATA);

    always_comb begin
        anyDemux = 1'b0;
        for (int i = 0; i <= ebu_pkg::WIN_NUM; i++) begin
            if (s_q.busCfg[i][ebu_pkg::CFG_ACTIVE] && !s_q.busCfg[i][ebu_pkg::CFG_MUX]) begin
                anyDemux = 1'b1;
            end
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.rspValid = 1'b0;
        if (anyDemux) begin
            s_d.addrPortBus = 1'b1;
        end
        if (regWe) begin
            if (regAddr == ebu_pkg::IDX_SYSCFG) begin
                s_d.sysCfg = regWdata;
            end
            if (regAddr == ebu_pkg::IDX_PORTDIR) begin
                s_d.portDir = regWdata;
            end
            if (regAddr == ebu_pkg::IDX_PORTOUT) begin
                s_d.portOut = regWdata;
            end
            for (int i = 0; i <= ebu_pkg::WIN_NUM; i++) begin
                if (regAddr == ebu_pkg::IDX_BUSCFG0 + 4'(i)) begin
                    s_d.busCfg[i] = regWdata;
                end
            end
            for (int i = 0; i < ebu_pkg::WIN_NUM; i++) begin
                if (regAddr == ebu_pkg::IDX_WINSEL1 + 4'(i)) begin
                    s_d.winSel[i] = regWdata;
                end
            end
        end
        s_d.regRdata = 16'h0000;
        if (regRe) begin
            case (regAddr)
                ebu_pkg::IDX_SYSCFG: begin
                    s_d.regRdata = s_q.sysCfg;
                end
                ebu_pkg::IDX_STATUS: begin
                    s_d.regRdata = {8'h00, s_q.addrPortBus, s_q.holdAck, s_q.win, s_q.phase};
                end
                ebu_pkg::IDX_PORTDIR: begin
                    s_d.regRdata = s_q.portDir;
                end
                ebu_pkg::IDX_PORTOUT: begin
                    s_d.regRdata = s_q.portOut;
                end
                ebu_pkg::IDX_PORTIN: begin
                    s_d.regRdata = addrSync;
                end
                default: begin
                    for (int i = 0; i <= ebu_pkg::WIN_NUM; i++) begin
                        if (regAddr == ebu_pkg::IDX_BUSCFG0 + 4'(i)) begin
                            s_d.regRdata = s_q.busCfg[i];
                        end
                    end
                    for (int i = 0; i < ebu_pkg::WIN_NUM; i++) begin
                        if (regAddr == ebu_pkg::IDX_WINSEL1 + 4'(i)) begin
                            s_d.regRdata = s_q.winSel[i];
                        end
                    end
                end
            endcase
        end
        case (s_q.phase)
            ebu_pkg::PH_IDLE: begin
                if (arbEn && !slave && !holdSyncN) begin
                    s_d.phase = ebu_pkg::PH_HELD;
                end else if (reqValid && reqReady) begin
                    s_d.req = req;
                    s_d.win = decWin;
                    s_d.cfg = decCfg;
                    s_d.second = 1'b0;
                    s_d.cnt = decCfg[ebu_pkg::CFG_ALE_LONG] ? ebu_pkg::ALE_LONG_CNT
                        : ebu_pkg::CNT_ZERO;
                    if (decCfg[ebu_pkg::CFG_ACTIVE]) begin
                        s_d.phase = ebu_pkg::PH_ADDR;
                    end else begin
                        s_d.rspValid = 1'b1;
                        s_d.rdata = 16'h0000;
                    end
                end
            end
            ebu_pkg::PH_ADDR: begin
                if (s_q.cnt != ebu_pkg::CNT_ZERO) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else begin
                    s_d.cnt = s_q.cfg[ebu_pkg::CFG_WAIT_LO +: 4];
                    s_d.phase = s_q.cfg[ebu_pkg::CFG_RW_DLY] ? ebu_pkg::PH_DELAY
                        : ebu_pkg::PH_DATA;
                end
            end
            ebu_pkg::PH_DELAY: begin
                s_d.phase = ebu_pkg::PH_DATA;
            end
            ebu_pkg::PH_DATA: begin
                if (s_q.cnt != ebu_pkg::CNT_ZERO) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else if (s_q.cfg[ebu_pkg::CFG_READY] && readySync) begin
                    s_d.cnt = ebu_pkg::CNT_ZERO;
                end else begin
                    if (!bus16) begin
                        if (s_q.second) begin
                            s_d.rdata[15:8] = adSync[7:0];
                        end else begin
                            s_d.rdata = {8'h00, adSync[7:0]};
                        end
                    end else if (s_q.req.byteAcc && s_q.req.addr[0]) begin
                        s_d.rdata = {8'h00, adSync[15:8]};
                    end else begin
                        s_d.rdata = adSync;
                    end
                    if (!bus16 && !s_q.req.byteAcc && !s_q.second) begin
                        s_d.second = 1'b1;
                        s_d.req.addr = s_q.req.addr + 24'h00_0001;
                        s_d.phase = ebu_pkg::PH_ADDR;
                        s_d.cnt = s_q.cfg[ebu_pkg::CFG_ALE_LONG] ? ebu_pkg::ALE_LONG_CNT
                            : ebu_pkg::CNT_ZERO;
                    end else begin
                        s_d.rspValid = 1'b1;
                        s_d.phase = s_q.cfg[ebu_pkg::CFG_TRI] ? ebu_pkg::PH_RECOVER
                            : ebu_pkg::PH_IDLE;
                    end
                end
            end
            ebu_pkg::PH_RECOVER: begin
                s_d.phase = ebu_pkg::PH_IDLE;
            end
            ebu_pkg::PH_HELD: begin
                s_d.holdAck = holdSyncN ? 1'b0 : 1'b1;
                if (holdSyncN) begin
                    s_d.phase = ebu_pkg::PH_IDLE;
                end
            end
            default: begin
                s_d.phase = ebu_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.phase <= ebu_pkg::PH_IDLE;
            s_q.sysCfg <= ebu_pkg::SYSCFG_RST;
            s_q.busCfg <= {5{ebu_pkg::BUSCFG_RST}};
            s_q.winSel <= {4{ebu_pkg::WINSEL_RST}};
            s_q.portDir <= ebu_pkg::PORT_RST;
            s_q.portOut <= ebu_pkg::PORT_RST;
            s_q.regRdata <= 16'h0000;
            s_q.req <= '0;
            s_q.win <= ebu_pkg::WIN_DEFAULT;
            s_q.cfg <= ebu_pkg::BUSCFG_RST;
            s_q.cnt <= ebu_pkg::CNT_ZERO;
            s_q.second <= 1'b0;
            s_q.addrPortBus <= 1'b0;
            s_q.holdAck <= 1'b0;
            s_q.rspValid <= 1'b0;
            s_q.rdata <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign laneData = s_q.req.byteAcc ? {2{s_q.req.wdata[7:0]}}
        : ((!bus16 && s_q.second) ? {8'h00, s_q.req.wdata[15:8]} : s_q.req.wdata);

    always_comb begin
        adPin.out = 16'h0000;
        adPin.oeN = 16'hffff;
        if (inCycle) begin
            if (mux && s_q.phase == ebu_pkg::PH_ADDR) begin
                adPin.out = s_q.req.addr[15:0];
                adPin.oeN = 16'h0000;
            end else if (s_q.req.write && s_q.phase == ebu_pkg::PH_DATA) begin
                adPin.out = laneData;
                adPin.oeN = bus16 ? 16'h0000 : 16'hff00;
            end
        end
    end

    always_comb begin
        if (s_q.addrPortBus) begin
            addrPin.out = s_q.req.addr[15:0];
            addrPin.oeN = (s_q.phase == ebu_pkg::PH_HELD) ? 16'hffff : 16'h0000;
        end else begin
            addrPin.out = s_q.portOut;
            addrPin.oeN = ~s_q.portDir;
        end
    end

    always_comb begin
        case (s_q.sysCfg[ebu_pkg::SYS_SEG_LO +: 2])
            ebu_pkg::SEG_16M: segMask = ebu_pkg::SEGMASK_16M;
            ebu_pkg::SEG_1M: segMask = ebu_pkg::SEGMASK_1M;
            ebu_pkg::SEG_256K: segMask = ebu_pkg::SEGMASK_256K;
            default: segMask = ebu_pkg::SEGMASK_64K;
        endcase
    end

    assign segOut = s_q.req.addr[23:16] & segMask;
    assign segOeN = (s_q.phase == ebu_pkg::PH_HELD) ? 8'hff : ~segMask;

    always_comb begin
        csN = 5'h1f;
        if (inCycle) begin
            csN[s_q.win] = 1'b0;
        end
    end

    assign ale = (s_q.phase == ebu_pkg::PH_ADDR);
    assign rdN = !(s_q.phase == ebu_pkg::PH_DATA && !s_q.req.write);
    assign wrN = !(s_q.phase == ebu_pkg::PH_DATA && s_q.req.write
        && (!s_q.cfg[ebu_pkg::CFG_WRL] || !bus16
        || (s_q.req.byteAcc && !s_q.req.addr[0])));
    assign strobeOeN = (s_q.phase == ebu_pkg::PH_HELD);
    assign holdAckOutN = !s_q.holdAck;
    assign holdAckOeN = !arbEn || slave;
    assign busReqN = !(arbEn && ((slave && reqValid && ackInSyncN)
        || (!slave && s_q.phase == ebu_pkg::PH_HELD && reqValid)));
    assign regRdata = s_q.regRdata;
    assign rspValid = s_q.rspValid;
    assign rspRdata = s_q.rdata;
endmodule : ebu_core

// File: verif/ebu_core_properties.sv
// Concurrent checks on the external bus unit ports.
`timescale 1ns/1ps
module ebu_core_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire ebu_pkg::ebu_pin16_t adPin,
    input wire logic [7:0] segOeN,
    input wire logic [4:0] csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic strobeOeN,
    input wire logic holdN,
    input wire logic holdAckOutN,
    input wire logic holdAckOeN
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence strobeOn;
        !rdN || !wrN;
    endsequence
    sequence holdGranted;
        !holdAckOutN && !holdAckOeN;
    endsequence
    sequence accessTaken;
        reqValid && reqReady;
    endsequence
    cs_one_hot_a: assert property ($onehot0(~csN))
        else $error("more than one chip select active");
    cs_idle_quiet_a: assert property (reqReady |-> csN == 5'h1f)
        else $error("chip select active while idle");
    strobe_exclusive_a: assert property (!(!rdN && !wrN))
        else $error("read and write strobes together");
    strobe_has_cs_a: assert property (strobeOn |-> csN != 5'h1f)
        else $error("strobe without chip select");
    write_drives_a: assert property (!wrN |-> adPin.oeN[7:0] == 8'h00)
        else $error("write data not driven");
    read_releases_a: assert property (!rdN |-> adPin.oeN[7:0] == 8'hff)
        else $error("data port driven during read");
    hold_float_a: assert property (holdGranted |-> adPin.oeN == 16'hffff && strobeOeN)
        else $error("bus not floated while held");
    hold_cause_a: assert property ($fell(holdAckOutN) |-> !$past(holdN, 1) && !$past(holdN, 3))
        else $error("acknowledge without hold request");
    seg_mask_a: assert property (segOeN inside {8'h00, 8'hf0, 8'hfc, 8'hff})
        else $error("segment lines not a legal width");
    answer_bound_a: assert property (accessTaken |-> ##[1:60] rspValid)
        else $error("access never answered");
endmodule : ebu_core_properties

bind ebu_core ebu_core_properties ebu_core_properties_i (.clk(clk), .rst(rst),
    .reqValid(reqValid), .reqReady(reqReady), .rspValid(rspValid), .adPin(adPin),
    .segOeN(segOeN), .csN(csN), .rdN(rdN), .wrN(wrN), .strobeOeN(strobeOeN),
    .holdN(holdN), .holdAckOutN(holdAckOutN), .holdAckOeN(holdAckOeN));

// File: verif/ebu_ext_mem.sv
// External word memory with a slow ready option on the far side of the bus.
`timescale 1ns/1ps
module ebu_ext_mem (
    input wire logic clk,
    input wire ebu_pkg::ebu_pin16_t adPin,
    input wire ebu_pkg::ebu_pin16_t addrPin,
    input wire logic ale,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic muxMode,
    input wire logic slow,
    output logic [15:0] adIn,
    output logic ready
);
    logic [15:0] mem [16];
    logic [15:0] latchAddr = 16'h0000;
    logic [15:0] lastVal = 16'h0000;
    logic [2:0] waitCnt = 3'h0;
    logic [15:0] curAddr;
    logic [15:0] extVal;
    assign curAddr = muxMode ? latchAddr : addrPin.out;
    assign extVal = !rdN ? mem[curAddr[4:1]] : ~lastVal;
    assign adIn = (~adPin.oeN & adPin.out) | (adPin.oeN & extVal);
    assign ready = slow && (!rdN || !wrN) && waitCnt < 3'h6;
    always @(posedge clk) begin
        if (ale) begin
            latchAddr <= adPin.out;
        end
        if (!wrN) begin
            mem[curAddr[4:1]] <= adPin.out;
        end
        lastVal <= adIn;
        waitCnt <= (!rdN || !wrN) ? ((waitCnt == 3'h7) ? waitCnt : waitCnt + 3'h1) : 3'h0;
    end
endmodule : ebu_ext_mem

// File: verif/ebu_core_tb.sv
// Self-checking bench for the external bus unit.
`timescale 1ns/1ps
module ebu_core_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWe = 1'b0;
    logic regRe = 1'b0;
    logic reqValid = 1'b0;
    ebu_pkg::ebu_req_t req = '0;
    logic holdN = 1'b1;
    logic muxMode = 1'b0;
    logic slow = 1'b0;
    logic [15:0] pinIn = 16'h0000;
    logic grantN = 1'b1;
    logic [15:0] regRdata, rspRdata, adIn, rv, rdat, wrData, aleAd, stAddr;
    logic reqReady, rspValid, ale, rdN, wrN, strobeOeN, ready;
    logic holdAckOutN, holdAckOeN, busReqN;
    logic [7:0] segOut, segOeN;
    logic [4:0] csN, seenCs;
    ebu_pkg::ebu_pin16_t adPin, addrPin;
    int err_total = 0;
    int check_count = 0;
    int lat, nWr, k;
    logic [7:0] segExp [4] = '{8'h00, 8'hf0, 8'hfc, 8'hff};
    logic [15:0] winSel [4] = '{16'h0101, 16'h0100, 16'h0201, 16'h0200};
    logic [23:0] wAddr [5] = '{24'h00_0002, 24'h01_0004, 24'h01_1006, 24'h02_0008, 24'h02_100a};
    logic [4:0] wCs [5] = '{5'h1e, 5'h1b, 5'h1d, 5'h0f, 5'h17};
    logic [15:0] cfgT [3] = '{16'h0903, 16'h0923, 16'h0963};

    always #5 clk = ~clk;

    ebu_core ebu_core_i (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWe(regWe), .regRe(regRe), .regRdata(regRdata), .reqValid(reqValid), .req(req),
        .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata), .adPin(adPin),
        .adIn(adIn), .addrPin(addrPin), .addrIn(pinIn), .segOut(segOut), .segOeN(segOeN),
        .csN(csN), .ale(ale), .rdN(rdN), .wrN(wrN), .strobeOeN(strobeOeN), .ready(ready),
        .holdN(holdN), .holdAckOutN(holdAckOutN), .holdAckOeN(holdAckOeN),
        .holdAckInN(grantN), .busReqN(busReqN));

    ebu_ext_mem ebu_ext_mem_i (.clk(clk), .adPin(adPin), .addrPin(addrPin), .ale(ale),
        .rdN(rdN), .wrN(wrN), .muxMode(muxMode), .slow(slow), .adIn(adIn), .ready(ready));

    task automatic check16(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : check16

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWe <= 1'b1;
        @(posedge clk);
        regWe <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRe <= 1'b1;
        @(posedge clk);
        regRe <= 1'b0;
        #1;
        rv = regRdata;
    endtask : rd_reg

    task automatic access(input logic w, input logic b, input logic [23:0] a,
        input logic [15:0] d);
        int n;
        logic pw;
        n = 0;
        pw = 1'b1;
        nWr = 0;
        seenCs = 5'h1f;
        @(posedge clk);
        reqValid <= 1'b1;
        req <= '{w, b, a, d};
        #1;
        while (!reqReady && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        reqValid <= 1'b0;
        lat = 1;
        #1;
        while (!rspValid && lat < 60) begin
            if (!wrN && pw) nWr++;
            pw = wrN;
            if (!wrN) wrData = adPin.out;
            if (ale) aleAd = adPin.out;
            if (!rdN || !wrN) stAddr = addrPin.out;
            seenCs = seenCs & csN;
            @(posedge clk);
            #1;
            lat++;
        end
        rdat = rspRdata;
        check16("access done", 16'h0001, {15'h0, rspValid});
    endtask : access

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_reg(4'h0);
        check16("syscfg", 16'h0000, rv);
        wr_reg(4'he, 16'hffff);
        rd_reg(4'he);
        check16("unmapped", 16'h0000, rv);
        check16("ack oe", 16'h0001, {15'h0, holdAckOeN});
        access(1'b1, 1'b0, 24'h00_0002, 16'h1111);
        check16("single lat", 16'h0001, 16'(lat));
        check16("single cs", 16'h001f, {11'h0, seenCs});
        for (int i = 0; i < 4; i++) begin
            wr_reg(4'h0, 16'(i * 2));
            repeat (2) @(posedge clk);
            #1;
            check16("seg oe", {8'h00, segExp[i]}, {8'h00, segOeN});
        end
        wr_reg(4'h2, 16'h00ff);
        wr_reg(4'h3, 16'h5a3c);
        pinIn <= 16'hc3a5;
        repeat (3) @(posedge clk);
        rd_reg(4'h4);
        check16("port in", 16'hc3a5, rv);
        check16("port oe", 16'hff00, addrPin.oeN);
        check16("port out", 16'h003c, {8'h00, addrPin.out[7:0]});
        for (int i = 0; i < 4; i++) wr_reg(4'(10 + i), winSel[i]);
        for (int i = 5; i < 10; i++) wr_reg(4'(i), 16'h0903);
        for (int i = 0; i < 5; i++) begin
            access(1'b1, 1'b0, wAddr[i], 16'h1000 + 16'(i));
            check16("cs", {11'h0, wCs[i]}, {11'h0, seenCs});
            check16("addr", wAddr[i][15:0], stAddr);
            check16("wdata", 16'h1000 + 16'(i), wrData);
            check16("nwr", 16'h0001, 16'(nWr));
            access(1'b0, 1'b0, wAddr[i], 16'h0000);
            check16("rdata", 16'h1000 + 16'(i), rdat);
        end
        for (int i = 0; i < 3; i++) begin
            wr_reg(4'h5, cfgT[i]);
            access(1'b1, 1'b0, 24'h00_0002, 16'h2222);
            check16("lat", 16'(6 + i), 16'(lat));
        end
        wr_reg(4'h5, 16'h0983);
        muxMode <= 1'b1;
        access(1'b1, 1'b0, 24'h00_000c, 16'hbeef);
        check16("ale addr", 16'h000c, aleAd);
        check16("mux data", 16'hbeef, wrData);
        check16("addr port", 16'h000c, stAddr);
        access(1'b0, 1'b0, 24'h00_000c, 16'h0000);
        check16("mux rdata", 16'hbeef, rdat);
        muxMode <= 1'b0;
        wr_reg(4'h5, 16'h0803);
        access(1'b1, 1'b0, 24'h00_0004, 16'h3344);
        check16("byte bus nwr", 16'h0002, 16'(nWr));
        wr_reg(4'h5, 16'h0b03);
        access(1'b1, 1'b1, 24'h00_0006, 16'h0055);
        check16("low nwr", 16'h0001, 16'(nWr));
        access(1'b1, 1'b1, 24'h00_0007, 16'h0066);
        check16("high nwr", 16'h0000, 16'(nWr));
        wr_reg(4'h5, 16'h0d03);
        slow <= 1'b1;
        access(1'b1, 1'b0, 24'h00_0002, 16'h7777);
        check16("ready wait", 16'h0001, {15'h0, lat > 6});
        slow <= 1'b0;
        wr_reg(4'h0, 16'h0001);
        repeat (2) @(posedge clk);
        #1;
        check16("master oe", 16'h0000, {15'h0, holdAckOeN});
        @(posedge clk);
        holdN <= 1'b0;
        k = 0;
        while (holdAckOutN !== 1'b0 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        check16("ack", 16'h0000, {15'h0, holdAckOutN});
        check16("ad float", 16'hffff, adPin.oeN);
        check16("held refuse", 16'h0000, {15'h0, reqReady});
        @(posedge clk);
        holdN <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check16("ack off", 16'h0001, {15'h0, holdAckOutN});
        wr_reg(4'h0, 16'h0009);
        repeat (2) @(posedge clk);
        #1;
        check16("slave oe", 16'h0001, {15'h0, holdAckOeN});
        @(posedge clk);
        reqValid <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check16("slave bus_request_out", 16'h0000, {15'h0, busReqN});
        check16("slave wait", 16'h0000, {15'h0, reqReady});
        @(posedge clk);
        grantN <= 1'b0;
        access(1'b0, 1'b0, 24'h02_100a, 16'h0000);
        check16("slave rdata", 16'h1004, rdat);
        check16("seg out", 16'h0002, {8'h00, segOut});
        finish_test();
    end
endmodule : ebu_core_tb
